// file: bold_params.svh
// Purpose: constants for the boolean output logic block
// Assumes: 32-bit classic wishbone, byte offsets below
// Notes: types live in bold_pkg
// Behaviour
// RULE1: output driven by bus or logic block
// RULE2: pin select then pin configure writes
// RULE3: output is OR of two AND terms
// RULE4: terms take first outputs, inputs, rail flags
// RULE5: one rail status kind per term
// RULE6: each active rail individually includable
// RULE7: latched flags held until bus or input clear
// RULE8: power good from measured monitor input
// RULE9: unmonitored rails excluded from power good
// RULE10: delay on assert, deassert, both, neither
// RULE11: normal delay filters out short glitches
// RULE12: ignore mode disregards input during delay
// RULE13: ignore mode short pulse still propagates
// RULE14: ignore mode pulses last at least delay
// RULE15: first eight outputs usable as dependencies
// RULE16: dependency uses logic state, not pin
// RULE17: pins driven low leaving reset
// RULE18: state machine mode selects one term
// RULE19: open drain or actively driven pins
// RULE20: undelayed edge follows result next cycle
`ifndef BOLD_PARAMS_SVH
`define BOLD_PARAMS_SVH

// ----------------------------------------
// sizes
// ----------------------------------------
`define BOLD_NUM_OUT 8
`define BOLD_NUM_IN 8
`define BOLD_NUM_RAIL 16
`define BOLD_NUM_LATCH 9

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define BOLD_ADR_PIN_SELECT 8'h00
`define BOLD_ADR_PIN_CONFIG 8'h04
`define BOLD_ADR_TERM0_INPUTS 8'h08
`define BOLD_ADR_TERM0_RAILS 8'h0c
`define BOLD_ADR_TERM1_INPUTS 8'h10
`define BOLD_ADR_TERM1_RAILS 8'h14
`define BOLD_ADR_LATCH_CLEAR 8'h18
`define BOLD_ADR_CLEAR_SOURCE 8'h1c
`define BOLD_ADR_MONITOR_EN 8'h20
`define BOLD_ADR_STATUS 8'h24

// ----------------------------------------
// pin config fields
// ----------------------------------------
`define BOLD_CFG_LOGIC 0
`define BOLD_CFG_VALUE 1
`define BOLD_CFG_ACT_HIGH 2
`define BOLD_CFG_OPEN_DRAIN 3
`define BOLD_CFG_DLY_ASSERT 4
`define BOLD_CFG_DLY_DEASSERT 5
`define BOLD_CFG_IGNORE 6
`define BOLD_CFG_STATE_MACHINE 7
`define BOLD_CFG_DELAY_LSB 16
`define BOLD_CFG_DELAY_MSB 31
`define BOLD_CFG_MASK 32'hffff_00ff

// ----------------------------------------
// term and clear-source fields
// ----------------------------------------
`define BOLD_TERM_OUT_LSB 0
`define BOLD_TERM_IN_LSB 8
`define BOLD_TERM_KIND_LSB 16
`define BOLD_CLR_ENABLE 3

// ----------------------------------------
// reset values
// ----------------------------------------
`define BOLD_CFG_RESET 32'h0000_0004
`define BOLD_MONITOR_RESET 16'hffff

// ----------------------------------------
// timing
// ----------------------------------------
`define BOLD_CLK_MHZ 50
`define BOLD_TICK_US 100

`endif

// file: bold_pkg.sv
// Purpose: shared types of the boolean output logic block
// Assumes: used with bold_params.svh
// Notes: all references written bold_pkg::name
package bold_pkg;

  typedef enum logic [4:0] {
    KIND_POWER_GOOD = 5'h00,
    KIND_MARGIN_EN = 5'h01,
    KIND_MARGIN_LOW = 5'h02,
    KIND_OV_FAULT = 5'h03,
    KIND_OV_WARN = 5'h04,
    KIND_UV_WARN = 5'h05,
    KIND_UV_FAULT = 5'h06,
    KIND_TON_FAULT = 5'h07,
    KIND_TOFF_WARN = 5'h08,
    KIND_SEQ_ON_TO = 5'h09,
    KIND_SEQ_OFF_TO = 5'h0a,
    KIND_WATCHDOG = 5'h0b,
    KIND_OV_FAULT_L = 5'h0c,
    KIND_OV_WARN_L = 5'h0d,
    KIND_UV_WARN_L = 5'h0e,
    KIND_UV_FAULT_L = 5'h0f,
    KIND_TON_FAULT_L = 5'h10,
    KIND_TOFF_WARN_L = 5'h11,
    KIND_SEQ_ON_TO_L = 5'h12,
    KIND_SEQ_OFF_TO_L = 5'h13,
    KIND_WATCHDOG_L = 5'h14
  } bold_kind_t;

  typedef struct packed {
    logic [15:0] power_good;
    logic [15:0] margin_en;
    logic [15:0] margin_direction_low;
    logic [15:0] over_voltage_fault_flag;
    logic [15:0] over_voltage_warning_flag;
    logic [15:0] under_voltage_warning_flag;
    logic [15:0] under_voltage_fault_flag;
    logic [15:0] turn_on_time_fault_flag;
    logic [15:0] turn_off_time_warning_flag;
    logic [15:0] sequence_on_timeout_flag;
    logic [15:0] sequence_off_timeout_flag;
    logic watchdog_timeout;
  } bold_rail_flags_t;

  typedef struct packed {
    logic [7:0] out_sel;
    logic [7:0] in_sel;
    bold_kind_t kind;
    logic [15:0] rail_sel;
  } bold_term_t;

  typedef enum logic [1:0] {
    DLY_IDLE = 2'b00,
    DLY_WAIT = 2'b01,
    DLY_HOLD = 2'b10
  } bold_dly_state_t;

endpackage

// file: bold_latch_bank.sv
// Purpose: sticky copies of rail status flags
// Assumes: clear is a level; set wins over clear
// Notes: one flop per flag
`timescale 1ns/1ps
module bold_latch_bank #(
  parameter int WIDTH = 144
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // flags
  input wire logic [WIDTH-1:0] raw_i,
  input wire logic clear_i,
  output logic [WIDTH-1:0] held_o
);

  logic [WIDTH-1:0] next_held;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_flag
      // RULE7: hold until cleared
      always_comb begin
        next_held[g] = raw_i[g] | (held_o[g] & ~clear_i);
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      held_o <= '0;
    end else begin
      held_o <= next_held;
    end
  end

endmodule

// file: bold_edge_delay.sv
// Purpose: per-output assertion and deassertion delay
// Assumes: tick_i pulses once per delay unit
// Notes: delay of n waits n to n+1 ticks
`timescale 1ns/1ps
module bold_edge_delay (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // settings
  input wire logic tick_i,
  input wire logic dly_assert_i,
  input wire logic dly_deassert_i,
  input wire logic ignore_i,
  input wire logic [15:0] delay_i,
  // result
  input wire logic raw_i,
  output logic state_o
);

  bold_pkg::bold_dly_state_t st, next_st;
  logic next_state;
  logic target, next_target;
  logic [15:0] cnt, next_cnt;
  logic need_dly;
  logic hold_on;

  always_comb begin
    need_dly = (raw_i ? dly_assert_i : dly_deassert_i) && (delay_i != 16'h0000);
    hold_on = ignore_i && (delay_i != 16'h0000);
    next_st = st;
    next_state = state_o;
    next_target = target;
    next_cnt = cnt;
    case (st)
      bold_pkg::DLY_IDLE: begin
        if (raw_i != state_o) begin
          next_cnt = 16'h0000;
          if (need_dly) begin
            // RULE10: edge with delay
            next_st = bold_pkg::DLY_WAIT;
            next_target = raw_i;
          end else begin
            // RULE20: undelayed edge follows
            next_state = raw_i;
            if (hold_on) begin
              next_st = bold_pkg::DLY_HOLD;
            end
          end
        end
      end
      bold_pkg::DLY_WAIT: begin
        if (!ignore_i && raw_i != target) begin
          // RULE11: reverted before expiry, dropped
          next_st = bold_pkg::DLY_IDLE;
        end else if (tick_i) begin
          if (cnt == delay_i) begin
            // RULE12: input ignored until here
            // RULE13: short pulse still shows
            next_state = target;
            next_cnt = 16'h0000;
            next_st = hold_on ? bold_pkg::DLY_HOLD : bold_pkg::DLY_IDLE;
          end else begin
            next_cnt = cnt + 16'h0001;
          end
        end
      end
      bold_pkg::DLY_HOLD: begin
        // RULE14: minimum pulse width
        if (tick_i) begin
          if (cnt == delay_i) begin
            next_st = bold_pkg::DLY_IDLE;
          end else begin
            next_cnt = cnt + 16'h0001;
          end
        end
      end
      default: begin
        next_st = bold_pkg::DLY_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= bold_pkg::DLY_IDLE;
      state_o <= 1'b0;
      target <= 1'b0;
      cnt <= 16'h0000;
    end else begin
      st <= next_st;
      state_o <= next_state;
      target <= next_target;
      cnt <= next_cnt;
    end
  end

endmodule

// file: bold_output_logic.sv
// Purpose: general outputs driven by bus or boolean logic with delay
// Assumes: classic wishbone slave, synchronous inputs, 50 MHz clock
// Notes: terms and pin config reached through the pin select register
`timescale 1ns/1ps
`include "bold_params.svh"
module bold_output_logic #(
  parameter int TICK_CYCLES = `BOLD_TICK_US * `BOLD_CLK_MHZ
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // status sources
  input wire logic [`BOLD_NUM_IN-1:0] general_input_i,
  input wire bold_pkg::bold_rail_flags_t rail_flags_i,
  // pins
  output logic [`BOLD_NUM_OUT-1:0] general_output_o,
  output logic [`BOLD_NUM_OUT-1:0] general_output_oe_o,
  // sequencing dependencies
  output logic [`BOLD_NUM_OUT-1:0] seq_dep_o
);

  localparam int N = `BOLD_NUM_OUT;
  localparam int R = `BOLD_NUM_RAIL;
  localparam int LW = `BOLD_NUM_LATCH * `BOLD_NUM_RAIL;

  // ----------------------------------------
  // register state
  // ----------------------------------------
  logic [2:0] pin_sel, next_pin_sel;
  logic [31:0] cfg [N];
  logic [31:0] next_cfg [N];
  bold_pkg::bold_term_t term0 [N];
  bold_pkg::bold_term_t term1 [N];
  bold_pkg::bold_term_t next_term0 [N];
  bold_pkg::bold_term_t next_term1 [N];
  logic [3:0] clr_src, next_clr_src;
  logic [R-1:0] mon_en, next_mon_en;
  logic bus_clear, next_bus_clear;
  logic ack, next_ack;
  logic [31:0] rdat, next_rdat;

  // ----------------------------------------
  // datapath signals
  // ----------------------------------------
  logic [LW-1:0] latch_raw;
  logic [LW-1:0] latch_held;
  logic latch_clear;
  logic [N-1:0] logic_state;
  logic [N-1:0] raw_result;
  logic [N-1:0] eff_state;
  logic [N-1:0] next_out, next_oe;
  logic [12:0] pre, next_pre;
  logic tick, next_tick;
  logic req;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // bus view of a term: output mask, input mask, status kind from bit 0 up
  function automatic logic [31:0] term_word(input bold_pkg::bold_term_t t);
    return {11'h000, t.kind, t.in_sel, t.out_sel};
  endfunction

  // ----------------------------------------
  // bus decode and register update
  // ----------------------------------------
  assign req = wb_cyc_i & wb_stb_i & ~ack;

  always_comb begin
    logic [31:0] w;
    w = 32'h0000_0000;
    next_pin_sel = pin_sel;
    next_cfg = cfg;
    next_term0 = term0;
    next_term1 = term1;
    next_clr_src = clr_src;
    next_mon_en = mon_en;
    next_bus_clear = 1'b0;
    next_ack = req;
    next_rdat = rdat;
    if (req && wb_we_i) begin
      case (wb_adr_i)
        // RULE2: select pin, then configure
        `BOLD_ADR_PIN_SELECT: begin
          w = merge({29'h0, pin_sel}, wb_dat_i, wb_sel_i);
          next_pin_sel = w[2:0];
        end
        // RULE1: logic or direct drive select
        `BOLD_ADR_PIN_CONFIG: begin
          w = merge(cfg[pin_sel], wb_dat_i, wb_sel_i);
          next_cfg[pin_sel] = w & `BOLD_CFG_MASK;
        end
        `BOLD_ADR_TERM0_INPUTS: begin
          w = merge(term_word(term0[pin_sel]), wb_dat_i, wb_sel_i);
          next_term0[pin_sel].out_sel = w[`BOLD_TERM_OUT_LSB +: 8];
          next_term0[pin_sel].in_sel = w[`BOLD_TERM_IN_LSB +: 8];
          next_term0[pin_sel].kind = bold_pkg::bold_kind_t'(w[`BOLD_TERM_KIND_LSB +: 5]);
        end
        `BOLD_ADR_TERM0_RAILS: begin
          w = merge({16'h0, term0[pin_sel].rail_sel}, wb_dat_i, wb_sel_i);
          next_term0[pin_sel].rail_sel = w[15:0];
        end
        `BOLD_ADR_TERM1_INPUTS: begin
          w = merge(term_word(term1[pin_sel]), wb_dat_i, wb_sel_i);
          next_term1[pin_sel].out_sel = w[`BOLD_TERM_OUT_LSB +: 8];
          next_term1[pin_sel].in_sel = w[`BOLD_TERM_IN_LSB +: 8];
          next_term1[pin_sel].kind = bold_pkg::bold_kind_t'(w[`BOLD_TERM_KIND_LSB +: 5]);
        end
        `BOLD_ADR_TERM1_RAILS: begin
          w = merge({16'h0, term1[pin_sel].rail_sel}, wb_dat_i, wb_sel_i);
          next_term1[pin_sel].rail_sel = w[15:0];
        end
        // RULE7: manufacturer-specific clear command
        `BOLD_ADR_LATCH_CLEAR: begin
          next_bus_clear = wb_sel_i[0] & wb_dat_i[0];
        end
        `BOLD_ADR_CLEAR_SOURCE: begin
          w = merge({28'h0, clr_src}, wb_dat_i, wb_sel_i);
          next_clr_src = w[3:0];
        end
        `BOLD_ADR_MONITOR_EN: begin
          w = merge({16'h0, mon_en}, wb_dat_i, wb_sel_i);
          next_mon_en = w[15:0];
        end
        default: begin
          w = 32'h0000_0000;
        end
      endcase
    end
    if (req && !wb_we_i) begin
      case (wb_adr_i)
        `BOLD_ADR_PIN_SELECT: next_rdat = {29'h0, pin_sel};
        `BOLD_ADR_PIN_CONFIG: next_rdat = cfg[pin_sel];
        `BOLD_ADR_TERM0_INPUTS: next_rdat = term_word(term0[pin_sel]);
        `BOLD_ADR_TERM0_RAILS: next_rdat = {16'h0, term0[pin_sel].rail_sel};
        `BOLD_ADR_TERM1_INPUTS: next_rdat = term_word(term1[pin_sel]);
        `BOLD_ADR_TERM1_RAILS: next_rdat = {16'h0, term1[pin_sel].rail_sel};
        `BOLD_ADR_CLEAR_SOURCE: next_rdat = {28'h0, clr_src};
        `BOLD_ADR_MONITOR_EN: next_rdat = {16'h0, mon_en};
        `BOLD_ADR_STATUS: next_rdat = {16'h0, general_output_o, eff_state};
        default: next_rdat = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_sel <= 3'h0;
      for (int i = 0; i < N; i++) begin
        cfg[i] <= `BOLD_CFG_RESET;
        term0[i] <= '0;
        term1[i] <= '0;
      end
      clr_src <= 4'h0;
      mon_en <= `BOLD_MONITOR_RESET;
      bus_clear <= 1'b0;
      ack <= 1'b0;
      rdat <= 32'h0000_0000;
    end else begin
      pin_sel <= next_pin_sel;
      cfg <= next_cfg;
      term0 <= next_term0;
      term1 <= next_term1;
      clr_src <= next_clr_src;
      mon_en <= next_mon_en;
      bus_clear <= next_bus_clear;
      ack <= next_ack;
      rdat <= next_rdat;
    end
  end

  assign wb_ack_o = ack;
  assign wb_dat_o = rdat;

  // ----------------------------------------
  // latched rail status
  // ----------------------------------------
  assign latch_raw = {{R{rail_flags_i.watchdog_timeout}},
                      rail_flags_i.sequence_off_timeout_flag,
                      rail_flags_i.sequence_on_timeout_flag,
                      rail_flags_i.turn_off_time_warning_flag,
                      rail_flags_i.turn_on_time_fault_flag,
                      rail_flags_i.under_voltage_fault_flag,
                      rail_flags_i.under_voltage_warning_flag,
                      rail_flags_i.over_voltage_warning_flag,
                      rail_flags_i.over_voltage_fault_flag};

  // RULE7: bus command or selected input clears
  assign latch_clear = bus_clear |
                       (clr_src[`BOLD_CLR_ENABLE] & general_input_i[clr_src[2:0]]);

  bold_latch_bank #(
    .WIDTH(LW)
  ) u_latch (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .raw_i(latch_raw),
    .clear_i(latch_clear),
    .held_o(latch_held)
  );

  // RULE5: one status kind per term
  function automatic logic [R-1:0] kind_flags(input bold_pkg::bold_kind_t k,
                                              input bold_pkg::bold_rail_flags_t f,
                                              input logic [LW-1:0] h,
                                              input logic [R-1:0] mon);
    logic [R-1:0] v;
    v = '0;
    case (k)
      // RULE8: measured power good
      // RULE9: unmonitored rails never match
      bold_pkg::KIND_POWER_GOOD: v = f.power_good & mon;
      bold_pkg::KIND_MARGIN_EN: v = f.margin_en;
      bold_pkg::KIND_MARGIN_LOW: v = f.margin_direction_low;
      bold_pkg::KIND_OV_FAULT: v = f.over_voltage_fault_flag;
      bold_pkg::KIND_OV_WARN: v = f.over_voltage_warning_flag;
      bold_pkg::KIND_UV_WARN: v = f.under_voltage_warning_flag;
      bold_pkg::KIND_UV_FAULT: v = f.under_voltage_fault_flag;
      bold_pkg::KIND_TON_FAULT: v = f.turn_on_time_fault_flag;
      bold_pkg::KIND_TOFF_WARN: v = f.turn_off_time_warning_flag;
      bold_pkg::KIND_SEQ_ON_TO: v = f.sequence_on_timeout_flag;
      bold_pkg::KIND_SEQ_OFF_TO: v = f.sequence_off_timeout_flag;
      bold_pkg::KIND_WATCHDOG: v = {R{f.watchdog_timeout}};
      bold_pkg::KIND_OV_FAULT_L: v = h[0*R +: R];
      bold_pkg::KIND_OV_WARN_L: v = h[1*R +: R];
      bold_pkg::KIND_UV_WARN_L: v = h[2*R +: R];
      bold_pkg::KIND_UV_FAULT_L: v = h[3*R +: R];
      bold_pkg::KIND_TON_FAULT_L: v = h[4*R +: R];
      bold_pkg::KIND_TOFF_WARN_L: v = h[5*R +: R];
      bold_pkg::KIND_SEQ_ON_TO_L: v = h[6*R +: R];
      bold_pkg::KIND_SEQ_OFF_TO_L: v = h[7*R +: R];
      bold_pkg::KIND_WATCHDOG_L: v = h[8*R +: R];
      default: v = '0;
    endcase
    return v;
  endfunction

  // an empty term reads false so an unused path never forces the output
  function automatic logic and_term(input bold_pkg::bold_term_t t,
                                    input logic [N-1:0] outs,
                                    input logic [`BOLD_NUM_IN-1:0] ins,
                                    input logic [R-1:0] rails);
    logic any;
    any = (t.out_sel != '0) | (t.in_sel != '0) | (t.rail_sel != '0);
    // RULE4: outputs, inputs and rail flags
    // RULE6: per-rail selection
    return any & (&(~t.out_sel | outs)) & (&(~t.in_sel | ins)) &
           (&(~t.rail_sel | rails));
  endfunction

  // ----------------------------------------
  // tick prescaler for delay units
  // ----------------------------------------
  always_comb begin
    next_tick = 1'b0;
    next_pre = pre + 13'h0001;
    if (pre == 13'(TICK_CYCLES - 1)) begin
      next_pre = 13'h0000;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre <= 13'h0000;
      tick <= 1'b0;
    end else begin
      pre <= next_pre;
      tick <= next_tick;
    end
  end

  // ----------------------------------------
  // per-output boolean block and delay
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_out
      logic t0, t1;
      always_comb begin
        t0 = and_term(term0[g], eff_state, general_input_i,
                      kind_flags(term0[g].kind, rail_flags_i, latch_held, mon_en));
        t1 = and_term(term1[g], eff_state, general_input_i,
                      kind_flags(term1[g].kind, rail_flags_i, latch_held, mon_en));
        if (cfg[g][`BOLD_CFG_STATE_MACHINE]) begin
          // RULE18: one path by current result
          raw_result[g] = logic_state[g] ? t0 : t1;
        end else begin
          // RULE3: OR of two AND terms
          raw_result[g] = t0 | t1;
        end
      end

      bold_edge_delay u_delay (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(tick),
        .dly_assert_i(cfg[g][`BOLD_CFG_DLY_ASSERT]),
        .dly_deassert_i(cfg[g][`BOLD_CFG_DLY_DEASSERT]),
        .ignore_i(cfg[g][`BOLD_CFG_IGNORE]),
        .delay_i(cfg[g][`BOLD_CFG_DELAY_MSB:`BOLD_CFG_DELAY_LSB]),
        .raw_i(raw_result[g]),
        .state_o(logic_state[g])
      );

      always_comb begin
        // RULE1: logic result or bus value
        eff_state[g] = cfg[g][`BOLD_CFG_LOGIC] ? logic_state[g] : cfg[g][`BOLD_CFG_VALUE];
        if (cfg[g][`BOLD_CFG_OPEN_DRAIN]) begin
          // RULE19: open drain only pulls low
          next_out[g] = 1'b0;
          next_oe[g] = ~(eff_state[g] ~^ cfg[g][`BOLD_CFG_ACT_HIGH]);
        end else begin
          next_out[g] = eff_state[g] ~^ cfg[g][`BOLD_CFG_ACT_HIGH];
          next_oe[g] = 1'b1;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // pin and dependency registers
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // RULE17: driven low out of reset
      general_output_o <= '0;
      general_output_oe_o <= '1;
      seq_dep_o <= '0;
    end else begin
      general_output_o <= next_out;
      general_output_oe_o <= next_oe;
      // RULE15: first eight usable as dependency
      // RULE16: logic state, not pin level
      seq_dep_o <= eff_state;
    end
  end

endmodule

// file: bold_output_logic_props.sv
// Purpose: bus and pin checks on bold_output_logic
// Assumes: one clock, synchronous reset
// Notes: bound at the foot of this file
`timescale 1ns/1ps
module bold_props (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // pins
  input wire logic [7:0] general_output_o,
  input wire logic [7:0] general_output_oe_o,
  input wire logic [7:0] seq_dep_o
);
  // ----
  // checks
  // ----
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  wire req = wb_cyc_i && wb_stb_i;
  a_ack_follows_req: assert property (req && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
    else $error("ack without request");
  a_ack_idle_bus: assert property (!req |=> !wb_ack_o)
    else $error("ack on idle bus");
  a_read_data_hold: assert property ($changed(wb_dat_o) |-> wb_ack_o && !$past(wb_we_i))
    else $error("read data moved");
  a_release_pins_low: assert property ($fell(rst_i) |-> general_output_o == 8'h00 && general_output_oe_o == 8'hff)
    else $error("pins not driven low");
  a_release_dep_clear: assert property ($fell(rst_i) |-> seq_dep_o == 8'h00 && !wb_ack_o)
    else $error("state not clear");
  a_open_drain_low: assert property ((general_output_o & ~general_output_oe_o) == 8'h00)
    else $error("undriven pin high");
  c_write: cover property (req && wb_we_i && wb_ack_o);
  c_read: cover property (req && !wb_we_i && wb_ack_o);
  c_pin_rise: cover property ($rose(general_output_o[1]));
endmodule
bind bold_output_logic bold_props bold_props_i (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i),
  .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o),
  .general_output_o(general_output_o),
  .general_output_oe_o(general_output_oe_o),
  .seq_dep_o(seq_dep_o)
);

// file: bold_pin_load.sv
// Purpose: far-side load on the output pins
// Assumes: every pin has a pull-up
// Notes: gives the level leds and switches see
`timescale 1ns/1ps
module bold_pin_load (
  // pins from the block
  input wire logic [7:0] pin_i,
  input wire logic [7:0] pin_oe_i,
  // seen level
  output logic [7:0] level_o
);
  // ----
  // released lines float up
  // ----
  assign level_o = (pin_i & pin_oe_i) | ~pin_oe_i;
endmodule

// file: bold_output_logic_tb.sv
// Purpose: self-checking bench of bold_output_logic
// Assumes: tick of 4 cycles, so delay n lasts 4n..4n+4 cycles
// Notes: expected levels come from the model here
`timescale 1ns/1ps
module bold_output_logic_tb;
  // ----
  // stimulus and model state
  // ----
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [7:0] inp = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [31:0] lf = 32'hc49d2505;
  logic [31:0] q;
  logic [31:0] r;
  logic [31:0] rdat;
  logic [7:0] pin;
  logic [7:0] oe;
  logic [7:0] dep;
  logic [7:0] lvl;
  logic ack;
  logic e;
  bold_pkg::bold_rail_flags_t flags = '0;
  int failures = 0;
  int compares = 0;
  int n;
  int f;
  always #10 clk_i = ~clk_i;
  bold_output_logic #(.TICK_CYCLES(4)) bold_output_logic_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wd),
    .wb_dat_o(rdat), .wb_ack_o(ack), .general_input_i(inp),
    .rail_flags_i(flags), .general_output_o(pin),
    .general_output_oe_o(oe), .seq_dep_o(dep));
  bold_pin_load bold_pin_load_i (.pin_i(pin), .pin_oe_i(oe), .level_o(lvl));
  function automatic logic [31:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf;
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    compares++;
    if (s !== x) begin
      failures++;
      $display("mismatch at %0t seen %h expected %h", $time, s, x);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    // only the watchdog ends a wait for ack
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    bus(1'b0, a, 32'h0);
    chk(q, x);
  endtask
  // counts cycles with pin 1 high
  task automatic hi(input int c);
    n = 0;
    repeat (c) begin
      @(posedge clk_i);
      n += int'(lvl[1]);
    end
  endtask
  task automatic tally_and_finish();
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    tally_and_finish();
  end
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk({pin, oe, dep}, 32'h00ff00);
    rd(8'h04, 32'h4);
    rd(8'h20, 32'hffff);
    wr(8'h3c, 32'hffffffff);
    rd(8'h3c, 32'h0);
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      wr(8'h00, 32'(i));
      wr(8'h04, {28'h0, r[3:1], 1'b0});
      hi(3);
      e = r[1] ~^ r[2];
      chk(dep[i], r[1]);
      chk({oe[i], lvl[i]}, {!r[3] || !e, e});
    end
    // pin 0: inputs 0 and 7 in one term, one rail kind in the other
    wr(8'h00, 32'h0);
    wr(8'h08, 32'h8100);
    wr(8'h14, 32'h1);
    wr(8'h04, 32'h5);
    for (int k = 0; k < 21; k++) begin
      flags <= '0;
      wr(8'h18, 32'h1);
      wr(8'h10, 32'(k) << 16);
      r = rnd();
      inp <= r[7:0];
      flags <= 177'({rnd(), rnd(), rnd(), rnd(), rnd(), rnd()});
      hi(5);
      f = k > 11 ? k - 9 : k;
      e = f == 11 ? flags.watchdog_timeout : flags[161 - 16 * f];
      chk(lvl[0], e | (inp[0] & inp[7]));
    end
    wr(8'h10, 32'h0);
    inp <= 8'h00;
    flags <= '1;
    wr(8'h20, 32'hfffe);
    hi(5);
    chk(lvl[0], 1'b0);
    wr(8'h10, 32'h140000);
    flags <= '0;
    hi(5);
    chk(lvl[0], 1'b1);
    wr(8'h1c, 32'hb);
    inp <= 8'h08;
    hi(5);
    chk(lvl[0], 1'b0);
    // pin 1 follows input 1 with a delay of two units
    inp <= 8'h00;
    wr(8'h00, 32'h1);
    wr(8'h08, 32'h200);
    wr(8'h04, 32'h20035);
    hi(20);
    inp <= 8'h02;
    hi(3);
    inp <= 8'h00;
    hi(20);
    chk(n, 0);
    inp <= 8'h02;
    hi(6);
    chk(n, 0);
    hi(14);
    chk(lvl[1], 1'b1);
    inp <= 8'h00;
    hi(6);
    chk(n, 6);
    hi(14);
    chk(lvl[1], 1'b0);
    wr(8'h04, 32'h20075);
    inp <= 8'h02;
    hi(2);
    inp <= 8'h00;
    hi(50);
    chk(n > 7, 1'b1);
    chk(lvl[1], 1'b0);
    // pin 2 state machine: input 3 sets it, input 2 alone holds it
    wr(8'h00, 32'h2);
    wr(8'h08, 32'h400);
    wr(8'h10, 32'h800);
    wr(8'h04, 32'h85);
    for (int j = 0; j < 4; j++) begin
      inp <= 8'(32'h00040c04 >> (8 * j));
      hi(5);
      chk(lvl[2], j == 1 || j == 2);
    end
    tally_and_finish();
  end
endmodule
